// *** hw/psda_bridge.v ***
// Program space data access bridge: table and visibility address generation, data steering
`timescale 1ns/1ns
`include "psda_map.vh"

module psda_bridge (
  input  wire        SYS_CLK_I,
  input  wire        RESET_I,
  // APB slave
  input  wire        PSEL_I,
  input  wire        PENABLE_I,
  input  wire        PWRITE_I,
  input  wire [11:0] PADDR_I,
  input  wire [31:0] PWDATA_I,
  output reg  [31:0] PRDATA_O,
  output wire        PREADY_O,
  output wire        PSLVERR_O,
  // CPU request side
  input  wire        REQ_VALID_I,
  input  wire [1:0]  REQ_KIND_I,
  input  wire        REQ_HIGH_I,
  input  wire        REQ_BYTE_I,
  input  wire [15:0] REQ_EA_I,
  input  wire [15:0] REQ_WDATA_I,
  input  wire [22:0] PC_I,
  input  wire        INSN_IS_MOVE_I,
  input  wire        IN_REPEAT_I,
  input  wire        REPEAT_EDGE_I,
  output wire        REQ_READY_O,
  output reg         RSP_VALID_O,
  output reg  [15:0] RSP_DATA_O,
  output reg  [1:0]  EXTRA_CYCLES_O,
  output wire [23:0] FETCH_ADDR_O,
  // Program memory side
  output reg         PM_REQ_O,
  output reg         PM_WRITE_O,
  output reg         PM_WR_HIGH_O,
  output reg  [23:0] PM_ADDR_O,
  output reg  [23:0] PM_WDATA_O,
  output reg         PM_CFG_SPACE_O,
  input  wire        PM_ACK_I,
  input  wire [23:0] PM_RDATA_I
);

  // --------------------------------------------------------------
  // Constants
  // --------------------------------------------------------------
  localparam [1:0] KIND_DATA  = 2'h0;
  localparam [1:0] KIND_TABLE = 2'h1;
  localparam [1:0] KIND_TBLWR = 2'h2;

  localparam [1:0] ST_IDLE    = 2'h0;
  localparam [1:0] ST_FETCH1  = 2'h1;
  localparam [1:0] ST_FETCH2  = 2'h2;
  localparam [1:0] ST_DONE    = 2'h3;

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  reg [7:0]  table_page_select_q;
  reg [7:0]  visibility_page_select_q;
  reg [15:0] core_control_q;
  reg [1:0]  state_q;
  reg        is_table_q;
  reg        is_high_q;
  reg        is_byte_q;
  reg        byte_sel_q;
  reg        is_write_q;
  reg        is_vis_q;
  reg [15:0] vis_wdata_q;
  reg [31:0] table_count_q;
  reg [31:0] vis_count_q;

  wire       visibility_enable = core_control_q[`PSDA_BIT_VIS_EN];
  wire       apb_wr = PSEL_I & PENABLE_I & PWRITE_I;
  wire       table_busy = (state_q != ST_IDLE) & is_table_q;

  // --------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------
  function [23:0] table_addr;
    input [7:0]  page;
    input [15:0] ea;
    begin
      table_addr = {page, ea};
    end
  endfunction

  function [23:0] vis_addr;
    input [7:0]  page;
    input [15:0] ea;
    begin
      vis_addr = {1'b0, page, ea[14:0]};
    end
  endfunction

  function [15:0] steer;
    input [23:0] p;
    input        high;
    input        bytem;
    input        bsel;
    begin
      if (!high && !bytem) begin
        steer = p[15:0];
      end else if (!high) begin
        steer = {8'h00, bsel ? p[15:8] : p[7:0]};
      end else if (!bytem) begin
        steer = {8'h00, p[23:16]};
      end else begin
        steer = bsel ? 16'h0000 : {8'h00, p[23:16]};
      end
    end
  endfunction

  function is_table_kind;
    input [1:0] kind;
    begin
      is_table_kind = (kind == KIND_TABLE) || (kind == KIND_TBLWR);
    end
  endfunction

  function redirect;
    input [15:0] ea;
    input        enable;
    begin
      redirect = ea[`PSDA_BIT_EA_TOP] & enable;
    end
  endfunction

  function [1:0] extra_cost;
    input move;
    input in_rep;
    input rep_edge;
    begin
      if (in_rep && !rep_edge) begin
        extra_cost = `PSDA_EXTRA_REP_MID;
      end else if (in_rep) begin
        extra_cost = `PSDA_EXTRA_OTHER;
      end else if (move) begin
        extra_cost = `PSDA_EXTRA_MOVE;
      end else begin
        extra_cost = `PSDA_EXTRA_OTHER;
      end
    end
  endfunction

  // --------------------------------------------------------------
  // Request decode
  // --------------------------------------------------------------
  wire        req_table   = is_table_kind(REQ_KIND_I);
  wire        req_write   = (REQ_KIND_I == KIND_TBLWR);
  wire        req_vis     = redirect(REQ_EA_I, visibility_enable);
  wire        req_byte_sel = REQ_EA_I[0];
  wire [15:0] req_ea_even = {REQ_EA_I[15:1], 1'b0};
  reg  [23:0] pm_addr_d;
  reg  [23:0] pm_wdata_d;
  reg         pm_cfg_d;
  reg  [1:0]  extra_d;
  reg  [15:0] rsp_data_d;

  // Address, space and cost of the request now offered
  always @* begin
    pm_addr_d  = 24'h000000;
    pm_wdata_d = 24'h000000;
    pm_cfg_d   = 1'b0;
    extra_d    = 2'h0;
    if (req_table) begin
      pm_addr_d = table_addr(table_page_select_q, req_ea_even);
      pm_cfg_d  = table_page_select_q[`PSDA_BIT_CFG_SPACE];
      if (REQ_HIGH_I) begin
        pm_wdata_d = {REQ_WDATA_I[7:0], 16'h0000};
      end else begin
        pm_wdata_d = {8'h00, REQ_WDATA_I};
      end
    end else if (req_vis) begin
      // Window reads never reach configuration space
      pm_addr_d = vis_addr(visibility_page_select_q, req_ea_even);
      extra_d   = extra_cost(INSN_IS_MOVE_I, IN_REPEAT_I, REPEAT_EDGE_I);
    end
  end

  // Data handed back once program memory answers
  always @* begin
    if (is_vis_q) begin
      rsp_data_d = PM_RDATA_I[15:0];
    end else if (is_write_q) begin
      rsp_data_d = 16'h0000;
    end else begin
      rsp_data_d = steer(PM_RDATA_I, is_high_q, is_byte_q, byte_sel_q);
    end
  end

  // --------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = 1'b0;

  wire        sel_table_page = (PADDR_I == `PSDA_OFS_TBL_PAGE);
  wire        sel_vis_page   = (PADDR_I == `PSDA_OFS_VIS_PAGE);
  wire        sel_core_ctl   = (PADDR_I == `PSDA_OFS_CORECTL);
  wire        sel_status     = (PADDR_I == `PSDA_OFS_STATUS);
  wire [31:0] status_word    = {28'h0000000, is_vis_q, table_busy, state_q};
  reg  [7:0]  table_page_select_d;
  reg  [7:0]  visibility_page_select_d;
  reg  [15:0] core_control_d;

  // Writes to unmapped offsets are dropped without an error
  always @* begin
    table_page_select_d      = table_page_select_q;
    visibility_page_select_d = visibility_page_select_q;
    core_control_d           = core_control_q;
    if (apb_wr) begin
      if (sel_table_page) begin
        table_page_select_d = PWDATA_I[7:0];
      end else if (sel_vis_page) begin
        visibility_page_select_d = PWDATA_I[7:0];
      end else if (sel_core_ctl) begin
        core_control_d = PWDATA_I[15:0];
      end
    end
  end

  always @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      table_page_select_q      <= `PSDA_RST_PAGE;
      visibility_page_select_q <= `PSDA_RST_PAGE;
      core_control_q           <= `PSDA_RST_CORECTL;
    end else begin
      table_page_select_q      <= table_page_select_d;
      visibility_page_select_q <= visibility_page_select_d;
      core_control_q           <= core_control_d;
    end
  end

  always @* begin
    if (sel_table_page) begin
      PRDATA_O = {24'h000000, table_page_select_q};
    end else if (sel_vis_page) begin
      PRDATA_O = {24'h000000, visibility_page_select_q};
    end else if (sel_core_ctl) begin
      PRDATA_O = {16'h0000, core_control_q};
    end else if (sel_status) begin
      PRDATA_O = status_word;
    end else begin
      PRDATA_O = 32'h00000000;
    end
  end

  // --------------------------------------------------------------
  // Code fetch address
  // --------------------------------------------------------------
  assign FETCH_ADDR_O = {1'b0, PC_I[22:1], 1'b0};

  // --------------------------------------------------------------
  // Request engine
  // --------------------------------------------------------------
  assign REQ_READY_O = (state_q == ST_IDLE);

  always @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      state_q        <= ST_IDLE;
      is_table_q     <= 1'b0;
      is_high_q      <= 1'b0;
      is_byte_q      <= 1'b0;
      byte_sel_q     <= 1'b0;
      is_write_q     <= 1'b0;
      is_vis_q       <= 1'b0;
      vis_wdata_q    <= 16'h0000;
      PM_REQ_O       <= 1'b0;
      PM_WRITE_O     <= 1'b0;
      PM_WR_HIGH_O   <= 1'b0;
      PM_ADDR_O      <= 24'h000000;
      PM_WDATA_O     <= 24'h000000;
      PM_CFG_SPACE_O <= 1'b0;
      RSP_VALID_O    <= 1'b0;
      RSP_DATA_O     <= 16'h0000;
      EXTRA_CYCLES_O <= 2'h0;
    end else begin
      RSP_VALID_O <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (REQ_VALID_I) begin
            is_high_q  <= REQ_HIGH_I;
            is_byte_q  <= REQ_BYTE_I;
            byte_sel_q <= req_byte_sel;
            if (req_table) begin
              is_table_q     <= 1'b1;
              is_vis_q       <= 1'b0;
              is_write_q     <= req_write;
              PM_REQ_O       <= 1'b1;
              PM_WRITE_O     <= req_write;
              PM_WR_HIGH_O   <= REQ_HIGH_I;
              PM_ADDR_O      <= pm_addr_d;
              PM_CFG_SPACE_O <= pm_cfg_d;
              PM_WDATA_O     <= pm_wdata_d;
              EXTRA_CYCLES_O <= extra_d;
              state_q        <= ST_FETCH2;
            end else if (req_vis) begin
              is_table_q     <= 1'b0;
              is_vis_q       <= 1'b1;
              is_write_q     <= 1'b0;
              vis_wdata_q    <= REQ_WDATA_I;
              PM_REQ_O       <= 1'b1;
              PM_WRITE_O     <= 1'b0;
              PM_WR_HIGH_O   <= 1'b0;
              PM_CFG_SPACE_O <= 1'b0;
              PM_ADDR_O      <= pm_addr_d;
              EXTRA_CYCLES_O <= extra_d;
              state_q        <= ST_FETCH1;
            end else begin
              is_vis_q       <= 1'b0;
              is_table_q     <= 1'b0;
              EXTRA_CYCLES_O <= 2'h0;
              RSP_DATA_O     <= 16'h0000;
              RSP_VALID_O    <= 1'b1;
            end
          end
        end
        ST_FETCH1: begin
          // First of two program memory fetches for a visibility read
          if (PM_ACK_I) begin
            state_q <= ST_FETCH2;
          end
        end
        ST_FETCH2: begin
          if (PM_ACK_I) begin
            PM_REQ_O   <= 1'b0;
            PM_WRITE_O <= 1'b0;
            // Response data is registered here, the valid pulse follows one edge later
            RSP_DATA_O <= rsp_data_d;
            state_q    <= ST_DONE;
          end
        end
        ST_DONE: begin
          RSP_VALID_O <= 1'b1;
          is_table_q  <= 1'b0;
          state_q     <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// *** hw/psda_map.vh ***
// Register offsets, field positions, reset values and timing counts for program space data access
//
// Behaviour
// - Table address is table page above EA.
// - Table page bit 7 picks configuration space.
// - Visibility address is page above EA 14:0.
// - Redirect only when EA bit 15 and enable.
// - Address bit 15 from page bit 0, bit 23 zero.
// - Addresses step by two per program word.
// - Word low read returns program bits 15:0.
// - Byte low read picks byte by select.
// - Word high read zeroes the phantom byte.
// - Byte high read, select one gives zero.
// - Only high operations reach upper program byte.
// - Visibility window is read-only, low word only.
// - Upper data half maps to 256 pages.
// - Visibility read needs two fetches, zero to two extra cycles.
// - Outside repeat: moves add one, others two.
// - Repeat first, last, interrupt edges add two.
// - Visibility suspended during table operations.
`ifndef PSDA_MAP_VH
`define PSDA_MAP_VH

`define PSDA_OFS_TBL_PAGE  12'h000
`define PSDA_OFS_VIS_PAGE  12'h004
`define PSDA_OFS_CORECTL   12'h008
`define PSDA_OFS_STATUS    12'h00c

`define PSDA_RST_PAGE      8'h00
`define PSDA_RST_CORECTL   16'h0000
`define PSDA_BIT_VIS_EN    2
`define PSDA_BIT_CFG_SPACE 7
`define PSDA_BIT_EA_TOP    15

`define PSDA_EXTRA_MOVE    2'h1
`define PSDA_EXTRA_OTHER   2'h2
`define PSDA_EXTRA_REP_MID 2'h0

`endif

// *** testbench/psda_properties.sv ***
// Checker for the program space data access bridge ports
`timescale 1ns/1ns
module psda_properties (
  input wire        SYS_CLK_I,
  input wire        RESET_I,
  input wire        REQ_VALID_I,
  input wire [1:0]  REQ_KIND_I,
  input wire [15:0] REQ_EA_I,
  input wire [22:0] PC_I,
  input wire        REQ_READY_O,
  input wire        RSP_VALID_O,
  input wire [15:0] RSP_DATA_O,
  input wire [1:0]  EXTRA_CYCLES_O,
  input wire [23:0] FETCH_ADDR_O,
  input wire        PM_REQ_O,
  input wire [23:0] PM_ADDR_O,
  input wire        PM_CFG_SPACE_O,
  input wire        PM_ACK_I
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);
  property p_fetch; FETCH_ADDR_O == {1'b0, PC_I[22:1], 1'b0}; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch address");
  property p_even; PM_REQ_O |-> !PM_ADDR_O[0]; endproperty
  a_even: assert property (p_even) else $error("odd address");
  property p_cfg; PM_REQ_O |-> PM_CFG_SPACE_O == PM_ADDR_O[23]; endproperty
  a_cfg: assert property (p_cfg) else $error("space select");
  property p_busy; PM_REQ_O |-> !REQ_READY_O; endproperty
  a_busy: assert property (p_busy) else $error("ready while busy");
  property p_plain; REQ_VALID_I && REQ_READY_O && REQ_KIND_I == 2'h0 && !REQ_EA_I[15]
    |=> RSP_VALID_O && RSP_DATA_O == 16'h0000 && !PM_REQ_O; endproperty
  a_plain: assert property (p_plain) else $error("low read redirected");
  property p_pulse; RSP_VALID_O |=> !RSP_VALID_O; endproperty
  a_pulse: assert property (p_pulse) else $error("long response");
  property p_hold; PM_REQ_O && !PM_ACK_I |=> PM_REQ_O && $stable(PM_ADDR_O); endproperty
  a_hold: assert property (p_hold) else $error("address moved");
  property p_extra; EXTRA_CYCLES_O != 2'h3; endproperty
  a_extra: assert property (p_extra) else $error("extra cycles");
  c_two: cover property (PM_REQ_O && PM_ACK_I ##[1:8] PM_REQ_O && PM_ACK_I);
  c_cfg: cover property (PM_REQ_O && PM_CFG_SPACE_O);
  c_rsp: cover property (RSP_VALID_O && EXTRA_CYCLES_O == 2'h2);
endmodule
bind psda_bridge psda_properties i_chk (.*);

// *** testbench/psda_pmem_model.sv ***
// Program memory model with prompt or slow acknowledge
`timescale 1ns/1ns
module psda_pmem_model (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        slow_i,
  input  wire        req_i,
  input  wire [23:0] addr_i,
  output reg         ack_o,
  output reg  [23:0] rdata_o
);
  reg  [1:0] wait_q;
  wire       go = req_i && !ack_o && !rst_i && (!slow_i || wait_q == 2'h3);
  always @(posedge clk_i) begin
    ack_o   <= go;
    wait_q  <= (req_i && !ack_o && !go) ? wait_q + 2'h1 : 2'h0;
    rdata_o <= rst_i ? 24'h0 : go ? {{8{addr_i[2]}}, addr_i[15:0] ^ 16'h5a3c} : ~rdata_o;
  end
endmodule

// *** testbench/test_program_space_data_access.sv ***
// Testbench for the program space data access bridge
`timescale 1ns/1ns
module test_program_space_data_access;
  reg SYS_CLK_I = 0, RESET_I = 1, PSEL_I = 0, PENABLE_I = 0, PWRITE_I = 0, REQ_VALID_I = 0;
  reg REQ_HIGH_I = 0, REQ_BYTE_I = 0, INSN_IS_MOVE_I = 0, IN_REPEAT_I = 0, REPEAT_EDGE_I = 0, slow = 0;
  reg [11:0] PADDR_I = 0;
  reg [31:0] PWDATA_I = 0, r;
  reg [1:0]  REQ_KIND_I = 0;
  reg [15:0] REQ_EA_I = 0, REQ_WDATA_I = 0, d;
  reg [22:0] PC_I = 23'h2aaaab;
  reg [24:0] pa;
  reg [23:0] pw, p;
  reg [3:0]  n;
  reg [1:0]  wf;
  wire [31:0] PRDATA_O;
  wire PREADY_O, PSLVERR_O, REQ_READY_O, RSP_VALID_O, PM_REQ_O, PM_WRITE_O, PM_WR_HIGH_O, PM_CFG_SPACE_O, PM_ACK_I;
  wire [15:0] RSP_DATA_O;
  wire [1:0]  EXTRA_CYCLES_O;
  wire [23:0] FETCH_ADDR_O, PM_ADDR_O, PM_WDATA_O, PM_RDATA_I;
  integer failures = 0, total_checks = 0, i;
  psda_bridge i_dut (.*);
  psda_pmem_model i_mem (.clk_i(SYS_CLK_I), .rst_i(RESET_I), .slow_i(slow), .req_i(PM_REQ_O),
    .addr_i(PM_ADDR_O), .ack_o(PM_ACK_I), .rdata_o(PM_RDATA_I));
  always #50 SYS_CLK_I = ~SYS_CLK_I;
  function [23:0] pat(input [23:0] a);
    pat = {{8{a[2]}}, a[15:0] ^ 16'h5a3c};
  endfunction
  task check(input [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task finish_test;
    if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task apb(input w, input [11:0] a, input [31:0] v);
    integer c;
    begin
      @(posedge SYS_CLK_I);
      PSEL_I <= 1;
      PENABLE_I <= 0;
      PWRITE_I <= w;
      PADDR_I <= a;
      PWDATA_I <= v;
      @(posedge SYS_CLK_I);
      PENABLE_I <= 1;
      c = 0;
      do begin @(posedge SYS_CLK_I); c++; end while (PREADY_O !== 1'b1 && c < 20);
      r = PRDATA_O;
      PSEL_I <= 0;
      PENABLE_I <= 0;
      if (c >= 20) begin failures++; finish_test; end
    end
  endtask
  task op(input [1:0] k, input hi, by, input [15:0] ea, wd);
    integer c;
    begin
      @(posedge SYS_CLK_I);
      REQ_VALID_I <= 1;
      REQ_KIND_I <= k;
      REQ_HIGH_I <= hi;
      REQ_BYTE_I <= by;
      REQ_EA_I <= ea;
      REQ_WDATA_I <= wd;
      pa = '1;
      n = 0;
      c = 0;
      do begin @(posedge SYS_CLK_I); c++; end while (REQ_READY_O !== 1'b1 && c < 50);
      REQ_VALID_I <= 0;
      do begin
        @(posedge SYS_CLK_I);
        c++;
        if (PM_REQ_O === 1'b1 && n == 0) begin
          pa = {PM_CFG_SPACE_O, PM_ADDR_O};
          pw = PM_WDATA_O;
          wf = {PM_WRITE_O, PM_WR_HIGH_O};
        end
        if (PM_REQ_O === 1'b1 && PM_ACK_I === 1'b1) n++;
      end while (RSP_VALID_O !== 1'b1 && c < 100);
      d = RSP_DATA_O;
      if (c >= 100) begin failures++; finish_test; end
    end
  endtask
  task t_regs;
    begin
      for (i = 0; i < 20; i += 4) begin apb(0, i, 0); check(r, 0); end
      apb(1, 12'h010, 32'hffff);
      apb(0, 12'h010, 0);
      check(r, 0);
      apb(1, 12'h000, 32'h1ff);
      apb(0, 12'h000, 0);
      check(r, 32'hff);
    end
  endtask
  task t_table;
    begin
      apb(1, 12'h000, 32'h12);
      p = pat(24'h121234);
      op(1, 0, 0, 16'h1234, 0);
      check(pa, {1'b0, 24'h121234});
      check(d, p[15:0]);
      check(n, 1);
      op(1, 0, 1, 16'h1235, 0);
      check(pa, {1'b0, 24'h121234});
      check(d[7:0], p[15:8]);
      op(1, 0, 1, 16'h1234, 0);
      check(d[7:0], p[7:0]);
      op(1, 1, 0, 16'h1234, 0);
      check(d, {8'h00, p[23:16]});
      op(1, 1, 1, 16'h1234, 0);
      check(d[7:0], p[23:16]);
      op(1, 1, 1, 16'h1235, 0);
      check(d[7:0], 0);
      op(2, 0, 0, 16'h2468, 16'hbeef);
      check({pa, pw[15:0]}, {25'h0122468, 16'hbeef});
      check(wf, 2'b10);
      op(2, 1, 0, 16'h2468, 16'h00c3);
      check(pw[23:16], 8'hc3);
      check(wf, 2'b11);
      check(FETCH_ADDR_O, 24'h2aaaaa);
      apb(1, 12'h000, 32'h85);
      op(1, 0, 0, 16'h0010, 0);
      check(pa, {1'b1, 8'h85, 16'h0010});
    end
  endtask
  task t_vis;
    begin
      apb(1, 12'h004, 32'h5b);
      apb(1, 12'h008, 32'h4);
      slow <= 1;
      p = pat({1'b0, 8'h5b, 15'h4246});
      op(0, 0, 0, 16'hc246, 0);
      check(pa, {2'b00, 8'h5b, 15'h4246});
      check(d, p[15:0]);
      check(wf, 2'b00);
      check(n, 2);
      for (i = 0; i < 4; i++) begin
        {INSN_IS_MOVE_I, IN_REPEAT_I, REPEAT_EDGE_I} <= 12'h81a >> (9 - 3 * i);
        op(0, 0, 0, 16'hc246, 0);
        check(EXTRA_CYCLES_O, 2'(8'h68 >> (6 - 2 * i)));
      end
      op(0, 0, 0, 16'h4246, 0);
      check({pa, d}, {25'h1ffffff, 16'h0});
      apb(1, 12'h008, 32'h0);
      op(0, 0, 0, 16'hc246, 0);
      check({pa, d}, {25'h1ffffff, 16'h0});
    end
  endtask
  initial begin
    repeat (16) @(posedge SYS_CLK_I);
    RESET_I <= 0;
    t_regs;
    t_table;
    t_vis;
    finish_test;
  end
endmodule
